// [bench/kmsc_operator.sv]
/*
  Operator at the keypad: one-cycle key events on request.
  Assumes the bench presses keys only after reset is released.
*/
`timescale 1ns/1ns
`default_nettype none
module kmsc_operator (
  input  wire logic       clk_in,
  output var  logic       key_valid_out,
  output var  logic [4:0] key_code_out
);
  initial
  begin
    key_valid_out = 1'b0;
    key_code_out  = 5'h00;
  end
  // Idle code is inverted so a stale code never repeats the key just pressed
  task automatic press(input logic [4:0] c);
    @(posedge clk_in);
    key_valid_out <= 1'b1;
    key_code_out  <= c;
    @(posedge clk_in);
    key_valid_out <= 1'b0;
    key_code_out  <= ~c;
    @(negedge clk_in);
  endtask : press
endmodule : kmsc_operator
`default_nettype wire

// [bench/test_keypad_menu_session_control.sv]
/*
  Self-checking bench for the keypad controller.
  Assumes short timer parameters and the operator model for keys.
*/
`timescale 1ns/1ns
`default_nettype none
module test_keypad_menu_session_control
  import kmsc_pkg::*;
;
  logic        clk_sys_in   = 1'b0;
  logic        rst_in       = 1'b1;
  logic        reg_wr_in    = 1'b0;
  logic        reg_rd_in    = 1'b0;
  logic [1:0]  reg_addr_in  = 2'h0;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        key_valid_in;
  logic [4:0]  key_code_in;
  logic [31:0] reg_rdata_out, entry_val_out, store_val_out;
  logic [3:0]  disp_msg_out;
  logic [7:0]  disp_cat_out, disp_item_out;
  logic        setting_wr_out, protect_halt_out, protect_reinit_out, led_green_out;
  logic        item_yesno_in      = 1'b0;
  logic        outputs_enabled_in = 1'b1;
  logic        crit_fail_in       = 1'b0;
  logic        action_go_out;
  logic [4:0]  disp_menu_out;
  logic [31:0] pw_disp_out;
  // Set lock, action lock, may set, may act, may view
  wire  [4:0]  rmt;
  int          n_mismatch = 0;
  int          num_checks = 0;

  always #50 clk_sys_in = ~clk_sys_in;

  kmsc_keypad_ctrl #(.INACT_CYC(36'h0_0000_0032), .PW_CYC(36'h0_0000_003C),
    .ENDED_CYC(36'h0_0000_0014))
    u_kmsc_keypad_ctrl (.clk_sys_in, .rst_in, .ce_in(1'b1), .key_valid_in, .key_code_in,
    .item_yesno_in, .outputs_enabled_in, .crit_fail_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .disp_msg_out,
    .disp_menu_out, .disp_cat_out, .disp_item_out, .entry_val_out, .pw_disp_out,
    .setting_wr_out, .action_go_out, .store_val_out, .protect_halt_out,
    .protect_reinit_out, .led_green_out, .remote_set_lock_out(rmt[4]),
    .remote_act_lock_out(rmt[3]), .remote_may_set_out(rmt[2]),
    .remote_may_act_out(rmt[1]), .remote_may_view_out(rmt[0]));

  kmsc_operator u_kmsc_operator (.clk_in(clk_sys_in), .key_valid_out(key_valid_in),
    .key_code_out(key_code_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wreg(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b0;
  endtask : wreg

  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [1:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b0;
    @(negedge clk_sys_in);
    chk(reg_rdata_out, exp);
  endtask : rreg

  task automatic key(input logic [4:0] c, input logic [3:0] m);
    u_kmsc_operator.press(c);
    chk(32'(disp_msg_out), 32'(m));
  endtask : key

  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(32'(disp_msg_out), 32'(M_BLANK));
    chk(32'(rmt), 32'h0000_0000);
    key(K_SET, M_CAT);
    key(K_PRINT, M_CAT);
    key(K_DOWN, M_CAT);
    chk(32'(disp_cat_out), 32'h0000_0007);
    key(K_UP, M_CAT);
    chk(32'(disp_cat_out), 32'h0000_0000);
    key(K_CONFIRM, M_PW);
    for (int i = 1; i < 5; i++) key(5'(i), M_PW);
    // Coded display is registered one cycle behind the digits
    @(negedge clk_sys_in);
    chk(pw_disp_out, 32'h4448_4C41);
    key(K_CONFIRM, M_ITEM);
    key(K_DOWN, M_ITEM);
    chk(32'(disp_item_out), 32'h0000_000F);
    key(K_UP, M_ITEM);
    key(K_SET, M_CAT);
    chk(32'(disp_menu_out), 32'(K_SET));
    key(K_CONFIRM, M_ITEM);
    key(K_UP, M_ITEM);
    chk(32'(disp_item_out), 32'h0000_0001);
    key(5'h08, M_ENTRY);
    key(K_DOT, M_ENTRY);
    key(K_ONE, M_ENTRY);
    chk(entry_val_out, 32'h0000_08A1);
    key(K_CONFIRM, M_ITEM);
    chk(32'(setting_wr_out), 32'h0000_0001);
    chk(store_val_out, 32'h0000_08A1);
    chk(32'(protect_halt_out), 32'h0000_0001);
    chk(32'(rmt), 32'h0000_0018);
    rreg(R_VALUE, 32'h0000_08A1);
    rreg(2'h3, 32'h0000_0000);
    wreg(R_CTRL, 32'h0000_0003);
    rreg(R_CTRL, 32'h0000_0003);
    chk(32'(rmt), 32'h0000_0019);
    key(K_ACT, M_CAT);
    key(K_CONFIRM, M_ITEM);
    key(5'h02, M_ENTRY);
    key(K_CONFIRM, M_ITEM);
    chk(32'({action_go_out, setting_wr_out}), 32'h0000_0002);
    chk(store_val_out, 32'h0000_0002);
    key(K_SET, M_CAT);
    key(K_CONFIRM, M_ITEM);
    @(posedge clk_sys_in);
    item_yesno_in <= 1'b1;
    key(K_THREE, M_NO);
    key(K_ONE, M_YES);
    key(5'h05, M_YES);
    key(K_CONFIRM, M_ITEM);
    chk(store_val_out, 32'h0000_0001);
    chk(32'(setting_wr_out), 32'h0000_0001);
    @(posedge clk_sys_in);
    item_yesno_in <= 1'b0;
    key(K_END, M_FINISH);
    key(K_CONFIRM, M_DONE);
    chk(32'({protect_reinit_out, led_green_out}), 32'h0000_0002);
    @(negedge clk_sys_in);
    chk(32'(protect_halt_out), 32'h0000_0000);
    chk(32'(led_green_out), 32'h0000_0001);
    chk(32'(rmt), 32'h0000_000D);
    key(K_END, M_FINISH);
    key(K_CONFIRM, M_ENDED);
    chk(32'(rmt), 32'h0000_0007);
    for (int i = 0; i < 40 && disp_msg_out !== M_BLANK; i++) @(negedge clk_sys_in);
    chk(32'(disp_msg_out), 32'(M_BLANK));
    key(K_INFO, M_CAT);
    key(K_CONFIRM, M_ITEM);
    key(5'h07, M_ITEM);
    for (int i = 0; i < 60 && disp_msg_out !== M_BLANK; i++) @(negedge clk_sys_in);
    chk(32'(disp_msg_out), 32'(M_BLANK));
    @(posedge clk_sys_in);
    crit_fail_in <= 1'b1;
    @(posedge clk_sys_in);
    crit_fail_in       <= 1'b0;
    outputs_enabled_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(32'(led_green_out), 32'h0000_0000);
    @(negedge clk_sys_in);
    chk(32'(led_green_out), 32'h0000_0000);
    final_report();
  end
endmodule : test_keypad_menu_session_control
`default_nettype wire

// [design/kmsc_keypad_ctrl.sv]
/*
  Front-panel keypad interpreter: menu scrolling, value entry, yes/no
  entry, password privileges, end-of-session sequence, status LED.
  Assumes key events, item type and relay status come from logic on
  clk_sys_in; registers via a plain strobe port, read data next cycle.
*/
`default_nettype none
`timescale 1ns/1ns
module kmsc_keypad_ctrl
  import kmsc_pkg::*;
#(
  parameter int            NUM_CAT   = 8,
  parameter int            NUM_ITEM  = 16,
  parameter logic [15:0]   MASTER_PW = 16'h1234, // Arbitrary value
  parameter logic [15:0]   SET_PW    = 16'h5678, // Arbitrary value
  parameter logic [TW-1:0] INACT_CYC = INACT_CYCLES,
  parameter logic [TW-1:0] PW_CYC    = INACT_CYCLES,
  parameter logic [TW-1:0] ENDED_CYC = ENDED_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        key_valid_in,
  input  wire logic [4:0]  key_code_in,
  input  wire logic        item_yesno_in,
  input  wire logic        outputs_enabled_in,
  input  wire logic        crit_fail_in,
  input  wire logic [1:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output logic      [3:0]  disp_msg_out,
  output logic      [4:0]  disp_menu_out,
  output logic      [7:0]  disp_cat_out,
  output logic      [7:0]  disp_item_out,
  output logic      [31:0] entry_val_out,
  output logic      [31:0] pw_disp_out,
  output logic             setting_wr_out,
  output logic             action_go_out,
  output logic      [31:0] store_val_out,
  output logic             protect_halt_out,
  output logic             protect_reinit_out,
  output logic             led_green_out,
  output logic             remote_set_lock_out,
  output logic             remote_act_lock_out,
  output logic             remote_may_set_out,
  output logic             remote_may_act_out,
  output logic             remote_may_view_out
);

  localparam int CW = $clog2(NUM_CAT);
  localparam int IW = $clog2(NUM_ITEM);
  localparam logic [CW-1:0] CAT_LAST  = CW'(NUM_CAT - 1);
  localparam logic [IW-1:0] ITEM_LAST = IW'(NUM_ITEM - 1);

  kmsc_state_t   st_q;
  kmsc_msg_t     msg_q;
  logic [4:0]    cmd_q;
  logic [CW-1:0] cat_q;
  logic [IW-1:0] item_q;
  logic [31:0]   entry_q;
  logic          yn_q;
  logic          close_q;
  logic          halt_q;
  logic          reinit_q;
  logic          session_q;
  logic          set_lock_q;
  logic          priv_set_q;
  logic          priv_act_q;
  logic          led_q;
  logic          wr_q;
  logic          act_q;
  logic [31:0]   val_q;
  logic [31:0]   pw_q;
  logic [31:0]   pw_code;
  logic [1:0]    lvl_q;
  logic [31:0]   rdata_q;

  logic kv, is_dig, is_data, is_cmd, key_yn, edit_ok, in_item;
  logic ev_conf, ev_store, ev_act, ev_fin, ev_pw_m, ev_pw_s;
  logic inact_exp, pw_exp, ended_exp, tmo;

  ////////////////////////////////////////////////////////////////////////
  // Key decode

  assign kv       = ce_in && key_valid_in && (key_code_in != K_PRINT);
  assign is_dig   = key_code_in <= K_NINE;
  assign is_data  = is_dig || (key_code_in == K_DOT);
  assign is_cmd   = key_code_in inside {K_INFO, K_SET, K_ACT};
  assign key_yn   = (key_code_in == K_ONE) || (key_code_in == K_THREE);
  assign in_item  = st_q inside {S_ITEM, S_ENTRY, S_YN};
  assign edit_ok  = ((cmd_q == K_SET) && priv_set_q) ||
                    ((cmd_q == K_ACT) && priv_act_q);
  assign ev_conf  = kv && (key_code_in == K_CONFIRM);
  assign ev_store = ev_conf && (cmd_q == K_SET) && (st_q inside {S_ENTRY, S_YN});
  assign ev_act   = ev_conf && (cmd_q == K_ACT) && (st_q inside {S_ENTRY, S_YN});
  assign ev_fin   = ev_conf && (st_q == S_FINISH);
  assign ev_pw_m  = ev_conf && (st_q == S_PW) && (entry_q[15:0] == MASTER_PW);
  assign ev_pw_s  = ev_conf && (st_q == S_PW) && (entry_q[15:0] == SET_PW);
  assign tmo      = inact_exp || ended_exp;

  ////////////////////////////////////////////////////////////////////////
  // Timers: inactivity, password life, completion message

  logic [2:0]    t_clr, t_run, t_exp;
  logic [TW-1:0] t_lim [3];

  assign t_clr[0] = kv;
  assign t_run[0] = (st_q != S_IDLE) || session_q;
  assign t_lim[0] = INACT_CYC;
  assign t_clr[1] = ev_pw_m || ev_pw_s || ev_store || ev_act;
  assign t_run[1] = priv_set_q || priv_act_q;
  assign t_lim[1] = PW_CYC;
  assign t_clr[2] = kv;
  assign t_run[2] = (st_q == S_ENDED) && close_q;
  assign t_lim[2] = ENDED_CYC;
  assign inact_exp = t_exp[0];
  assign pw_exp    = t_exp[1];
  assign ended_exp = t_exp[2];

  for (genvar g = 0; g < 3; g++)
  begin : g_tmr
    logic [TW-1:0] cnt_q;
    always_ff @(posedge clk_sys_in)
    begin
      if (rst_in)
        cnt_q <= '0;
      else if (ce_in)
      begin
        if (t_clr[g] || !t_run[g])
          cnt_q <= '0;
        else if (cnt_q != t_lim[g])
          cnt_q <= cnt_q + TW'(1);
      end
    end
    // Saturating count gives one expiry pulse per idle stretch
    assign t_exp[g] = ce_in && t_run[g] && !t_clr[g] && (cnt_q == t_lim[g] - TW'(1));
  end

  ////////////////////////////////////////////////////////////////////////
  // Navigation and display

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      st_q    <= S_IDLE;
      msg_q   <= M_BLANK;
      cmd_q   <= K_INFO;
      cat_q   <= '0;
      item_q  <= '0;
      entry_q <= '0;
      yn_q    <= 1'b0;
      close_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (tmo)
      begin
        st_q    <= S_IDLE;
        msg_q   <= M_BLANK;
        entry_q <= '0;
      end
      else if (kv)
      begin
        if (is_cmd)
        begin
          st_q    <= S_CAT;
          msg_q   <= M_CAT;
          entry_q <= '0;
          if (!(in_item && (key_code_in == cmd_q)))
          begin
            cmd_q <= key_code_in;
            cat_q <= '0;
          end
        end
        else if (key_code_in == K_END)
        begin
          st_q  <= S_FINISH;
          msg_q <= M_FINISH;
        end
        else if ((st_q == S_ENDED) || ((st_q == S_FINISH) && !ev_conf))
        begin
          st_q  <= S_IDLE;
          msg_q <= M_BLANK;
        end
        else
        begin
          case (key_code_in)
            K_UP, K_DOWN:
            begin
              if (st_q == S_CAT)
              begin
                if (key_code_in == K_UP)
                  cat_q <= (cat_q == CAT_LAST) ? '0 : cat_q + CW'(1);
                else
                  cat_q <= (cat_q == '0) ? CAT_LAST : cat_q - CW'(1);
              end
              else if (in_item)
              begin
                if (key_code_in == K_UP)
                  item_q <= (item_q == ITEM_LAST) ? '0 : item_q + IW'(1);
                else
                  item_q <= (item_q == '0) ? ITEM_LAST : item_q - IW'(1);
                st_q    <= S_ITEM;
                msg_q   <= M_ITEM;
                entry_q <= '0;
              end
            end
            K_ERASE:
            begin
              entry_q <= '0;
              if (st_q == S_PW)
                msg_q <= M_PW;
              else if (st_q inside {S_ENTRY, S_YN})
              begin
                st_q  <= S_ITEM;
                msg_q <= M_ITEM;
              end
              else
              begin
                st_q  <= S_IDLE;
                msg_q <= M_BLANK;
              end
            end
            K_CONFIRM:
            begin
              case (st_q)
                S_CAT:
                begin
                  item_q  <= '0;
                  entry_q <= '0;
                  if ((cmd_q != K_INFO) && (cat_q == '0) && !edit_ok)
                  begin
                    st_q  <= S_PW;
                    msg_q <= M_PW;
                  end
                  else
                  begin
                    st_q  <= S_ITEM;
                    msg_q <= M_ITEM;
                  end
                end
                S_PW:
                begin
                  st_q    <= S_ITEM;
                  msg_q   <= (ev_pw_m || ev_pw_s) ? M_ITEM : M_DENIED;
                  entry_q <= '0;
                end
                S_ENTRY, S_YN:
                begin
                  st_q  <= S_ITEM;
                  msg_q <= M_ITEM;
                end
                S_FINISH:
                begin
                  st_q    <= S_ENDED;
                  msg_q   <= halt_q ? M_DONE : M_ENDED;
                  close_q <= !halt_q;
                end
                default:
                begin
                end
              endcase
            end
            default:
            begin
              if ((st_q == S_PW) && is_dig)
                entry_q <= {entry_q[27:0], key_code_in[3:0]};
              else if (in_item && edit_ok && is_data)
              begin
                if (item_yesno_in)
                begin
                  if (key_yn)
                  begin
                    st_q  <= S_YN;
                    yn_q  <= key_code_in == K_ONE;
                    msg_q <= (key_code_in == K_ONE) ? M_YES : M_NO;
                  end
                end
                else
                begin
                  st_q    <= S_ENTRY;
                  msg_q   <= M_ENTRY;
                  entry_q <= {entry_q[27:0], key_code_in[3:0]};
                end
              end
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Store, protection halt, locks, privileges, LED

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wr_q  <= 1'b0;
      act_q <= 1'b0;
      val_q <= '0;
    end
    else if (ce_in)
    begin
      wr_q  <= ev_store;
      act_q <= ev_act;
      if (ev_store || ev_act)
        val_q <= (st_q == S_YN) ? (yn_q ? 32'h0000_0001 : 32'h0000_0003) : entry_q;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      halt_q   <= 1'b0;
      reinit_q <= 1'b0;
    end
    else if (ce_in)
    begin
      reinit_q <= ev_fin && halt_q;
      if (ev_store)
        halt_q <= 1'b1;
      else if (ev_fin)
        halt_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      session_q  <= 1'b0;
      set_lock_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if ((ev_fin && !halt_q) || inact_exp)
        session_q <= 1'b0;
      else if (kv)
        session_q <= 1'b1;
      if (ev_store)
        set_lock_q <= 1'b1;
      else if (ev_fin || inact_exp)
        set_lock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      priv_set_q <= 1'b0;
      priv_act_q <= 1'b0;
    end
    else if (ce_in)
    begin
      if (ev_pw_m || ev_pw_s)
        priv_set_q <= 1'b1;
      else if (ev_fin || pw_exp || inact_exp)
        priv_set_q <= 1'b0;
      if (ev_pw_m)
        priv_act_q <= 1'b1;
      else if ((ev_fin && !halt_q) || pw_exp || inact_exp)
        priv_act_q <= 1'b0;
    end
  end

  // Tracks relay status whenever protection runs, so it settles after reinit
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      led_q <= 1'b0;
    else if (ce_in)
      led_q <= !halt_q && outputs_enabled_in && !crit_fail_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // Password display

  kmsc_pw_code #(
    .N (4)
  ) u_code (
    .plain_in  ({4'h3, entry_q[15:12], 4'h3, entry_q[11:8],
                 4'h3, entry_q[7:4], 4'h3, entry_q[3:0]}),
    .coded_out (pw_code)
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      pw_q <= '0;
    else if (ce_in)
      pw_q <= (st_q == S_PW) ? pw_code : '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      lvl_q   <= LV_NONE;
      rdata_q <= '0;
    end
    else if (ce_in)
    begin
      if (reg_wr_in && (reg_addr_in == R_CTRL))
        lvl_q <= reg_wdata_in[1:0];
      rdata_q <= '0;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          R_STATUS: rdata_q <= {23'h00_0000, st_q, led_q, priv_act_q, priv_set_q,
                                set_lock_q, session_q, halt_q};
          R_CTRL:   rdata_q <= {30'h0000_0000, lvl_q};
          R_VALUE:  rdata_q <= val_q;
          default:  rdata_q <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_out       = rdata_q;
  assign disp_msg_out        = msg_q;
  assign disp_menu_out       = cmd_q;
  assign disp_cat_out        = 8'(cat_q);
  assign disp_item_out       = 8'(item_q);
  assign entry_val_out       = entry_q;
  assign pw_disp_out         = pw_q;
  assign setting_wr_out      = wr_q;
  assign action_go_out       = act_q;
  assign store_val_out       = val_q;
  assign protect_halt_out    = halt_q;
  assign protect_reinit_out  = reinit_q;
  assign led_green_out       = led_q;
  assign remote_set_lock_out = set_lock_q;
  assign remote_act_lock_out = session_q;
  assign remote_may_set_out  = (lvl_q inside {LV_SET, LV_MASTER}) && !set_lock_q;
  assign remote_may_act_out  = (lvl_q == LV_MASTER) && !session_q;
  assign remote_may_view_out = lvl_q != LV_NONE;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_print_ignored: assert property (
    ce_in && key_valid_in && (key_code_in == K_PRINT) && !tmo
    |=> $stable(st_q) && $stable(msg_q))
    else $error("print key changed state");

  a_cat_up_wrap: assert property (
    kv && !tmo && (key_code_in == K_UP) && (st_q == S_CAT) && (cat_q == CAT_LAST)
    |=> cat_q == '0)
    else $error("category up did not wrap");

  a_cat_down_wrap: assert property (
    kv && !tmo && (key_code_in == K_DOWN) && (st_q == S_CAT) && (cat_q == '0)
    |=> cat_q == CAT_LAST)
    else $error("category down did not wrap");

  a_item_next: assert property (
    kv && !tmo && (key_code_in == K_UP) && in_item && (item_q != ITEM_LAST)
    |=> (item_q - $past(item_q) == IW'(1)) && (msg_q == M_ITEM))
    else $error("up did not advance item");

  a_cat_select: assert property (
    ev_conf && !tmo && (st_q == S_CAT) && ((cmd_q == K_INFO) || (cat_q != '0))
    |=> (st_q == S_ITEM) && (item_q == '0))
    else $error("confirm did not show first item");

  a_halt_on_store: assert property (
    setting_wr_out |-> protect_halt_out ##1 protect_halt_out || $past(ev_fin))
    else $error("halt missing after store");

  a_finish_prompt: assert property (
    kv && !tmo && (key_code_in == K_END) |=> msg_q == M_FINISH ##0 st_q == S_FINISH)
    else $error("end key did not prompt");

  a_reinit_done: assert property (
    ev_fin && halt_q
    |=> protect_reinit_out && !protect_halt_out && (msg_q == M_DONE) && session_q
    ##1 !protect_reinit_out)
    else $error("end with halt did not reinit");

  a_yn_echo: assert property (
    kv && in_item && edit_ok && item_yesno_in && (key_code_in == K_THREE)
    |=> (msg_q == M_NO) && (st_q == S_YN))
    else $error("no key not echoed");

  a_edit_gate: assert property (
    kv && !tmo && is_data && (st_q == S_ITEM) && !edit_ok |=> st_q == S_ITEM)
    else $error("edit without privilege");

endmodule : kmsc_keypad_ctrl
`default_nettype wire

// [design/kmsc_pw_code.sv]
/*
  Fixed character substitution used to show passwords on the display.
  Purely combinational; the caller registers the result.
*/
`default_nettype none
`timescale 1ns/1ns
module kmsc_pw_code #(
  parameter int N = 4
) (
  input  wire logic [8*N-1:0] plain_in,
  output logic      [8*N-1:0] coded_out
);

  function automatic logic [7:0] enc(input logic [7:0] c);
    case (c)
      "P":     enc = " ";
      "T":     enc = "!";
      "X":     enc = "\"";
      "Q":     enc = "$";
      "U":     enc = "%";
      "Y":     enc = "&";
      "R":     enc = "(";
      "V":     enc = ")";
      "Z":     enc = "*";
      "S":     enc = ",";
      "W":     enc = "-";
      "D":     enc = "1";
      "H":     enc = "2";
      "L":     enc = "3";
      "A":     enc = "4";
      "E":     enc = "5";
      "I":     enc = "6";
      "M":     enc = "7";
      "B":     enc = "8";
      "F":     enc = "9";
      "J":     enc = ":";
      "N":     enc = ".";
      "C":     enc = "<";
      "G":     enc = "=";
      "K":     enc = ">";
      "O":     enc = "?";
      "0":     enc = "@";
      "4":     enc = "A";
      "8":     enc = "B";
      "1":     enc = "D";
      "5":     enc = "E";
      "9":     enc = "F";
      "2":     enc = "H";
      "6":     enc = "I";
      "3":     enc = "L";
      "7":     enc = "M";
      " ":     enc = "P";
      "$":     enc = "Q";
      "(":     enc = "R";
      ",":     enc = "S";
      "!":     enc = "T";
      "%":     enc = "U";
      ")":     enc = "V";
      "-":     enc = "W";
      "\"":    enc = "X";
      "&":     enc = "Y";
      "*":     enc = "Z";
      "#":     enc = "\\";
      "'":     enc = "]";
      "+":     enc = "^";
      "/":     enc = "_";
      default: enc = " ";
    endcase
  endfunction : enc

  for (genvar g = 0; g < N; g++)
  begin : g_chr
    assign coded_out[8*g+:8] = enc(plain_in[8*g+:8]);
  end

endmodule : kmsc_pw_code
`default_nettype wire

// [shared/kmsc_pkg.sv]
/*
  Constants for the keypad menu and session controller: key codes,
  display messages, states, register map, privilege levels, timings.
  Assumes a single 10 MHz system clock.
*/
`default_nettype none
package kmsc_pkg;

  // Key codes; digits 0..9 use their own value
  localparam logic [4:0] K_ONE     = 5'h01;
  localparam logic [4:0] K_THREE   = 5'h03;
  localparam logic [4:0] K_NINE    = 5'h09;
  localparam logic [4:0] K_DOT     = 5'h0A;
  localparam logic [4:0] K_UP      = 5'h0B;
  localparam logic [4:0] K_DOWN    = 5'h0C;
  localparam logic [4:0] K_CONFIRM = 5'h0D;
  localparam logic [4:0] K_END     = 5'h0E;
  localparam logic [4:0] K_ERASE   = 5'h0F;
  localparam logic [4:0] K_PRINT   = 5'h10;
  localparam logic [4:0] K_INFO    = 5'h11;
  localparam logic [4:0] K_SET     = 5'h12;
  localparam logic [4:0] K_ACT     = 5'h13;

  // Gray codes along idle, category, item, entry
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_CAT    = 3'h1,
    S_ITEM   = 3'h3,
    S_ENTRY  = 3'h2,
    S_YN     = 3'h6,
    S_PW     = 3'h7,
    S_FINISH = 3'h5,
    S_ENDED  = 3'h4
  } kmsc_state_t;

  typedef enum logic [3:0] {
    M_BLANK  = 4'h0,
    M_CAT    = 4'h1,
    M_ITEM   = 4'h2,
    M_ENTRY  = 4'h3,
    M_YES    = 4'h4,
    M_NO     = 4'h5,
    M_PW     = 4'h6,
    M_FINISH = 4'h7,
    M_ENDED  = 4'h8,
    M_DONE   = 4'h9,
    M_DENIED = 4'hA
  } kmsc_msg_t;

  // Register word addresses
  localparam logic [1:0] R_STATUS = 2'h0;
  localparam logic [1:0] R_CTRL   = 2'h1;
  localparam logic [1:0] R_VALUE  = 2'h2;

  // Remote privilege levels
  localparam logic [1:0] LV_NONE   = 2'h0;
  localparam logic [1:0] LV_VIEW   = 2'h1;
  localparam logic [1:0] LV_SET    = 2'h2;
  localparam logic [1:0] LV_MASTER = 2'h3;

  localparam int TW = 36;
  localparam longint CLK_HZ      = 10_000_000;
  localparam longint INACT_S     = 900;
  localparam longint ENDED_S     = 10;
  localparam logic [TW-1:0] INACT_CYCLES = TW'(INACT_S * CLK_HZ);
  localparam logic [TW-1:0] ENDED_CYCLES = TW'(ENDED_S * CLK_HZ);

endpackage : kmsc_pkg
`default_nettype wire
